// ==== rtl/lsp_pkg.sv ====
// shared constants, register map and carrier types of the lcd shared io ports
package lsp_pkg;

  // ==========================================================================
  // register map, byte addresses on the apb bus
  localparam logic [7:0] OFF_PORT_C_DATA_LATCH = 8'h00;
  localparam logic [7:0] OFF_PORT_C_DIRECTION = 8'h04;
  localparam logic [7:0] OFF_PORT_E_DATA_LATCH = 8'h08;
  localparam logic [7:0] OFF_PORT_E_DIRECTION = 8'h0c;
  localparam logic [7:0] OFF_LCD_ENABLE_REG_ONE = 8'h10;
  localparam logic [7:0] OFF_LCD_ENABLE_REG_THREE = 8'h14;
  localparam logic [7:0] OFF_LCD_ENABLE_REG_FOUR = 8'h18;
  localparam logic [7:0] OFF_LCD_ENABLE_REG_FIVE = 8'h1c;
  localparam logic [7:0] OFF_LCD_ENABLE_REG_SIX = 8'h20;
  localparam logic [7:0] OFF_STANDBY_CONTROL_REG = 8'h24;
  localparam logic [7:0] OFF_PORT_C_RMW_VIEW = 8'h28;
  localparam logic [7:0] OFF_PORT_E_RMW_VIEW = 8'h2c;

  // ==========================================================================
  // field positions and widths
  localparam int PORT_INPUT_CTRL_POS = 0;
  localparam int STANDBY_PIN_FLOAT_POS = 0;
  localparam int SEG_C_LOW_W = 6;
  localparam int SEG_C_HIGH_W = 2;
  localparam int SEG_E_LOW_W = 2;
  localparam int SEG_E_HIGH_W = 6;
  localparam int PORT_W = 8;
  localparam int PIN_COUNT = 16;
  localparam int PIN_TIMER1_OUT_B = 13;
  localparam int PIN_TIMER1_OUT_A = 14;
  localparam int PIN_TIMER1_EXT_CLOCK = 15;

  // ==========================================================================
  // reset values
  localparam logic [7:0] RST_DATA_LATCH = 8'h00;
  localparam logic [7:0] RST_DIRECTION = 8'h00;
  localparam logic [7:0] RST_LCD_SELECT = 8'h00;
  localparam logic RST_PORT_INPUT_CTRL = 1'b1;
  localparam logic RST_STANDBY_PIN_FLOAT = 1'b0;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } lsp_apb_req_type;

  typedef struct packed {
    logic [7:0] e;
    logic [7:0] c;
  } lsp_pins_type;

endpackage : lsp_pkg

// ==== rtl/lsp_ports.sv ====
// two lcd shared general purpose io ports with apb register access
//
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
// Functional notes
// - direction bit one makes pin an output
// - output pin driven from its data latch bit
// - data write stored, appears on output pins
// - output pin reads back latch, not pin
// - direction bit zero makes pin an input
// - write to input pin only updates latch
// - input reads pin level; rmw read latch
// - zero means low, one means high
// - bits seven..zero map onto pins seven..zero
// - port e selects from two enable fields
// - peripheral output enable overrides port drive
// - peripheral driven pin reads pin level
// - peripheral input pins read pin level
// - timer one outputs pins five, six; clock seven
// - reset clears all direction bits
// - float bit in standby forces high impedance
// - floated pin input held low internally
// - float bit zero keeps pin state
module lsp_ports (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire lsp_pkg::lsp_apb_req_type apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire lsp_pkg::lsp_pins_type pin_in,
  output lsp_pkg::lsp_pins_type pin_out,
  output lsp_pkg::lsp_pins_type pin_oe,
  input wire lsp_pkg::lsp_pins_type lcd_seg_value,
  input wire logic standby_active,
  input wire logic timer1_out_a,
  input wire logic timer1_out_a_en,
  input wire logic timer1_out_b,
  input wire logic timer1_out_b_en,
  output logic timer1_ext_clock
);
  import lsp_pkg::*;

  // ==========================================================================
  // address decode
  function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] off);
    return addr == off;
  endfunction : addr_is

  logic [7:0] port_c_data_latch_r;
  logic [7:0] port_c_direction_r;
  logic [7:0] port_e_data_latch_r;
  logic [7:0] port_e_direction_r;
  logic port_input_ctrl_r;
  logic [SEG_C_LOW_W-1:0] lcd_enable_reg_three_r;
  logic [SEG_C_HIGH_W-1:0] lcd_enable_reg_four_r;
  logic [SEG_E_LOW_W-1:0] lcd_enable_reg_five_r;
  logic [SEG_E_HIGH_W-1:0] lcd_enable_reg_six_r;
  logic standby_pin_float_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic [PIN_COUNT-1:0] pin_out_r;
  logic [PIN_COUNT-1:0] pin_oe_r;
  logic timer1_ext_clock_r;

  wire [7:0] paddr = apb_req.paddr;
  wire setup_phase = apb_req.psel & ~apb_req.penable;
  wire access_done = apb_req.psel & apb_req.penable & pready_r;
  wire wr_en = access_done & apb_req.pwrite;
  wire [7:0] wdata8 = apb_req.pwdata[7:0];

  wire hit_c_data = addr_is(paddr, OFF_PORT_C_DATA_LATCH);
  wire hit_c_dir = addr_is(paddr, OFF_PORT_C_DIRECTION);
  wire hit_e_data = addr_is(paddr, OFF_PORT_E_DATA_LATCH);
  wire hit_e_dir = addr_is(paddr, OFF_PORT_E_DIRECTION);
  wire hit_one = addr_is(paddr, OFF_LCD_ENABLE_REG_ONE);
  wire hit_three = addr_is(paddr, OFF_LCD_ENABLE_REG_THREE);
  wire hit_four = addr_is(paddr, OFF_LCD_ENABLE_REG_FOUR);
  wire hit_five = addr_is(paddr, OFF_LCD_ENABLE_REG_FIVE);
  wire hit_six = addr_is(paddr, OFF_LCD_ENABLE_REG_SIX);
  wire hit_stby = addr_is(paddr, OFF_STANDBY_CONTROL_REG);
  wire hit_c_rmw = addr_is(paddr, OFF_PORT_C_RMW_VIEW);
  wire hit_e_rmw = addr_is(paddr, OFF_PORT_E_RMW_VIEW);
  wire hit_any = hit_c_data | hit_c_dir | hit_e_data | hit_e_dir | hit_one | hit_three | hit_four |
                 hit_five | hit_six | hit_stby | hit_c_rmw | hit_e_rmw;

  // ==========================================================================
  // per pin configuration vectors, port c in bits 7..0, port e in bits 15..8
  wire float_on = standby_pin_float_r & standby_active;
  wire [PIN_COUNT-1:0] latch_v = {port_e_data_latch_r, port_c_data_latch_r};
  wire [PIN_COUNT-1:0] dir_v = {port_e_direction_r, port_c_direction_r};
  wire [PIN_COUNT-1:0] lcd_sel_v = {lcd_enable_reg_six_r, lcd_enable_reg_five_r,
                                    lcd_enable_reg_four_r, lcd_enable_reg_three_r};
  wire [PIN_COUNT-1:0] seg_v = {lcd_seg_value.e, lcd_seg_value.c};
  wire [PIN_COUNT-1:0] pin_in_v = {pin_in.e, pin_in.c};
  wire [PIN_COUNT-1:0] periph_en_v;
  wire [PIN_COUNT-1:0] periph_val_v;
  wire [PIN_COUNT-1:0] oe_nxt;
  wire [PIN_COUNT-1:0] out_nxt;
  wire [PIN_COUNT-1:0] in_gated;
  wire [PIN_COUNT-1:0] rd_plain;

  // only pins e5 and e6 carry a peripheral output
  assign periph_en_v = PIN_COUNT'(timer1_out_b_en) << PIN_TIMER1_OUT_B |
                       PIN_COUNT'(timer1_out_a_en) << PIN_TIMER1_OUT_A;
  assign periph_val_v = PIN_COUNT'(timer1_out_b) << PIN_TIMER1_OUT_B |
                        PIN_COUNT'(timer1_out_a) << PIN_TIMER1_OUT_A;

  // ==========================================================================
  // pin slices
  genvar gi;
  generate
    for (gi = 0; gi < PIN_COUNT; gi++) begin : g_slice
      // float beats segment drive beats peripheral drive beats port drive
      assign oe_nxt[gi] = ~float_on & (lcd_sel_v[gi] | periph_en_v[gi] | dir_v[gi]);
      assign out_nxt[gi] = float_on ? 1'b0 :
                           lcd_sel_v[gi] ? seg_v[gi] :
                           periph_en_v[gi] ? periph_val_v[gi] : latch_v[gi];
      // input path clamped low so a floating pin cannot leak
      assign in_gated[gi] = pin_in_v[gi] & ~float_on & port_input_ctrl_r;
      // a port-driven output reads its latch, anything else the pin
      assign rd_plain[gi] = (dir_v[gi] & ~lcd_sel_v[gi] & ~periph_en_v[gi]) ? latch_v[gi]
                                                                            : in_gated[gi];
    end
  endgenerate

  // ==========================================================================
  // read mux
  wire [7:0] stby_rd = 8'(standby_pin_float_r) << STANDBY_PIN_FLOAT_POS;
  wire [7:0] ctrl_rd = 8'(port_input_ctrl_r) << PORT_INPUT_CTRL_POS;
  wire [7:0] rd_sel =
    hit_c_data ? rd_plain[7:0] :
    hit_e_data ? rd_plain[15:8] :
    hit_c_rmw ? port_c_data_latch_r :
    hit_e_rmw ? port_e_data_latch_r :
    hit_c_dir ? port_c_direction_r :
    hit_e_dir ? port_e_direction_r :
    hit_one ? ctrl_rd :
    hit_three ? 8'(lcd_enable_reg_three_r) :
    hit_four ? 8'(lcd_enable_reg_four_r) :
    hit_five ? 8'(lcd_enable_reg_five_r) :
    hit_six ? 8'(lcd_enable_reg_six_r) :
    hit_stby ? stby_rd : 8'h00;

  // ==========================================================================
  // apb slave: read data captured in the setup cycle, one access cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= setup_phase;
      pslverr_r <= setup_phase & ~hit_any;
      if (setup_phase) begin
        prdata_r <= {24'h00_0000, rd_sel};
      end
    end
  end

  // ==========================================================================
  // port registers; the rmw views write the same latches
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_c_data_latch_r <= RST_DATA_LATCH;
      port_e_data_latch_r <= RST_DATA_LATCH;
      port_c_direction_r <= RST_DIRECTION;
      port_e_direction_r <= RST_DIRECTION;
    end else begin
      if (wr_en & (hit_c_data | hit_c_rmw)) begin
        port_c_data_latch_r <= wdata8;
      end
      if (wr_en & (hit_e_data | hit_e_rmw)) begin
        port_e_data_latch_r <= wdata8;
      end
      if (wr_en & hit_c_dir) begin
        port_c_direction_r <= wdata8;
      end
      if (wr_en & hit_e_dir) begin
        port_e_direction_r <= wdata8;
      end
    end
  end

  // ==========================================================================
  // lcd function selects and standby control
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_input_ctrl_r <= RST_PORT_INPUT_CTRL;
      lcd_enable_reg_three_r <= SEG_C_LOW_W'(RST_LCD_SELECT);
      lcd_enable_reg_four_r <= SEG_C_HIGH_W'(RST_LCD_SELECT);
      lcd_enable_reg_five_r <= SEG_E_LOW_W'(RST_LCD_SELECT);
      lcd_enable_reg_six_r <= SEG_E_HIGH_W'(RST_LCD_SELECT);
      standby_pin_float_r <= RST_STANDBY_PIN_FLOAT;
    end else begin
      if (wr_en & hit_one) begin
        port_input_ctrl_r <= wdata8[PORT_INPUT_CTRL_POS];
      end
      if (wr_en & hit_three) begin
        lcd_enable_reg_three_r <= wdata8[SEG_C_LOW_W-1:0];
      end
      if (wr_en & hit_four) begin
        lcd_enable_reg_four_r <= wdata8[SEG_C_HIGH_W-1:0];
      end
      if (wr_en & hit_five) begin
        lcd_enable_reg_five_r <= wdata8[SEG_E_LOW_W-1:0];
      end
      if (wr_en & hit_six) begin
        lcd_enable_reg_six_r <= wdata8[SEG_E_HIGH_W-1:0];
      end
      if (wr_en & hit_stby) begin
        standby_pin_float_r <= wdata8[STANDBY_PIN_FLOAT_POS];
      end
    end
  end

  // ==========================================================================
  // registered pin drivers; one cycle from a register change to the pad
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_out_r <= '0;
      pin_oe_r <= '0;
      timer1_ext_clock_r <= 1'b0;
    end else begin
      pin_out_r <= out_nxt;
      pin_oe_r <= oe_nxt;
      timer1_ext_clock_r <= in_gated[PIN_TIMER1_EXT_CLOCK];
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign pin_out = pin_out_r;
  assign pin_oe = pin_oe_r;
  assign timer1_ext_clock = timer1_ext_clock_r;

  // ==========================================================================
  // checks
  sequence read_setup_s(logic hit);
    apb_req.psel && !apb_req.penable && !apb_req.pwrite && hit;
  endsequence

  sequence write_access_s(logic hit);
    apb_req.psel && apb_req.penable && pready_r && apb_req.pwrite && hit;
  endsequence

  dir_reset_a: assert property (@(posedge sys_clk) $rose(rst_n) |-> dir_v == 16'h0000)
    else $error("direction bits not cleared by reset");

  out_enable_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!float_on && lcd_sel_v[7:0] == 8'h00) |=> pin_oe_r[7:0] == $past(port_c_direction_r))
    else $error("port c enables do not follow direction");

  out_value_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!float_on && lcd_sel_v[7:0] == 8'h00) |=>
      (pin_out_r[7:0] & pin_oe_r[7:0]) == $past(port_c_data_latch_r & port_c_direction_r))
    else $error("port c output value differs from latch");

  latch_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    write_access_s(hit_c_data) |=> port_c_data_latch_r == $past(apb_req.pwdata[7:0]))
    else $error("port c latch not written");

  input_no_drive_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (port_e_direction_r == 8'h00 && lcd_sel_v[15:8] == 8'h00 && periph_en_v == '0) ##1
      (port_e_direction_r == 8'h00) |-> pin_oe_r[15:8] == 8'h00)
    else $error("input pin on port e is driven");

  out_readback_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (read_setup_s(hit_c_data) and (lcd_sel_v[7:0] == 8'h00)) |=>
      (prdata_r[7:0] & $past(port_c_direction_r)) == $past(port_c_data_latch_r & port_c_direction_r))
    else $error("output pin read does not return latch");

  rmw_readback_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    read_setup_s(hit_e_rmw) |=> (pready_r && prdata_r[7:0] == $past(port_e_data_latch_r)))
    else $error("rmw view does not return latch");

  rmw_port_c_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    read_setup_s(hit_c_rmw) |=>
      prdata_r[7:0] == $past(port_c_data_latch_r))
    else $error("port c rmw view does not return latch");

  input_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (read_setup_s(hit_c_data) and (port_c_direction_r == 8'h00) and (!float_on && port_input_ctrl_r)) |=>
      prdata_r[7:0] == $past(pin_in.c))
    else $error("input pin read does not return pin level");

  input_clamp_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (read_setup_s(hit_c_data) and (port_c_direction_r == 8'h00) and !port_input_ctrl_r) |=>
      prdata_r[7:0] == 8'h00)
    else $error("disabled port input not read as low");

  dir_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    write_access_s(hit_e_dir) |=>
      port_e_direction_r == $past(apb_req.pwdata[7:0]))
    else $error("port e direction not written");

  seg_drive_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!float_on && lcd_sel_v[0]) |=>
      pin_oe_r[0] && pin_out_r[0] == $past(lcd_seg_value.c[0]))
    else $error("segment value not driven on pin c0");

  seg_port_e_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!float_on && lcd_enable_reg_six_r[0]) |=>
      pin_oe_r[10] && pin_out_r[10] == $past(lcd_seg_value.e[2]))
    else $error("segment select of pin e2 not taken from its field");

  periph_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (read_setup_s(hit_e_data) and (timer1_out_a_en && !float_on && port_input_ctrl_r) and
      !lcd_sel_v[PIN_TIMER1_OUT_A]) |=> prdata_r[6] == $past(pin_in.e[6]))
    else $error("peripheral driven pin not read as pin level");

  float_low_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    float_on |=>
      pin_out_r == 16'h0000)
    else $error("floated pins keep an output value");

  ignore_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    write_access_s(!hit_any) |=>
      port_c_data_latch_r == $past(port_c_data_latch_r) && dir_v == $past(dir_v))
    else $error("write to unmapped address changed a register");

  float_pins_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    float_on [*2] |-> pin_oe_r == '0)
    else $error("pins driven during floated standby");

  float_input_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (read_setup_s(hit_c_data) and float_on) |=> prdata_r[7:0] == $past(latch_v[7:0] & dir_v[7:0] &
      ~lcd_sel_v[7:0]))
    else $error("floated input not clamped low");

  timer_out_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (timer1_out_b_en && !float_on && !lcd_sel_v[PIN_TIMER1_OUT_B]) |=>
      pin_oe_r[PIN_TIMER1_OUT_B] && pin_out_r[PIN_TIMER1_OUT_B] == $past(timer1_out_b))
    else $error("timer output not routed to pin e5");

  ext_clock_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!float_on && port_input_ctrl_r) |=> timer1_ext_clock_r == $past(pin_in.e[7]))
    else $error("timer clock input not taken from pin e7");

  apb_answer_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (apb_req.psel && !apb_req.penable) |=> pready_r && (pslverr_r == $past(!hit_any)))
    else $error("apb answer missing or wrong error flag");

endmodule : lsp_ports

// ==== testbench/lsp_pad_model.sv ====
// pad model: external drivers and floating lines around the port pins
`timescale 1ns/1ps
module lsp_pad_model (
  input wire logic sys_clk,
  input wire lsp_pkg::lsp_pins_type pin_out,
  input wire lsp_pkg::lsp_pins_type pin_oe,
  input wire lsp_pkg::lsp_pins_type ext_val,
  input wire lsp_pkg::lsp_pins_type ext_en,
  output lsp_pkg::lsp_pins_type pin_in
);
  import lsp_pkg::*;
  logic [15:0] float_r = 16'h5555;
  // undriven pads toggle every cycle so a stale level never passes for a read
  always @(posedge sys_clk) begin
    float_r <= ~float_r;
  end
  assign pin_in = lsp_pins_type'((pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) | (~pin_oe & ~ext_en & float_r));
endmodule : lsp_pad_model

// ==== testbench/test_lcd_shared_io_ports.sv ====
// self-checking bench of the lcd shared io ports
`timescale 1ns/1ps
module test_lcd_shared_io_ports;
  import lsp_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  lsp_apb_req_type apb_req = '0;
  logic [31:0] prdata;
  logic pready, pslverr, timer1_ext_clock;
  lsp_pins_type pin_in, pin_out, pin_oe;
  lsp_pins_type lcd_seg_value = '0, ext_val = '0, ext_en = '0;
  logic standby_active = 1'b0, ta = 1'b0, ta_en = 1'b0, tb = 1'b0, tb_en = 1'b0;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;

  lsp_ports u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .apb_req(apb_req), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .lcd_seg_value(lcd_seg_value),
    .standby_active(standby_active), .timer1_out_a(ta), .timer1_out_a_en(ta_en), .timer1_out_b(tb),
    .timer1_out_b_en(tb_en), .timer1_ext_clock(timer1_ext_clock));
  lsp_pad_model u_pad (.sys_clk(sys_clk), .pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val),
    .ext_en(ext_en), .pin_in(pin_in));

  initial begin
    forever #50 sys_clk = ~sys_clk;
  end
  // the whole run needs well under a thousand cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      $display("[FAIL] %0t run did not finish", $time);
      end_of_test();
    end
  end

  // ==========================================================================
  // shared tasks
  task end_of_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge sys_clk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge sys_clk);
    apb_req.penable <= 1'b1;
    // look between edges so the answer is settled; it then holds up to the completing edge
    do begin
      @(negedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    r = prdata;
    e = pslverr;
    @(posedge sys_clk);
    apb_req <= '0;
    if (n == 16) chk(32'h1, 32'h0);
  endtask : apb

  task wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, {24'h0, d}, r, e);
  endtask : wr

  task rd(input logic [7:0] a, input logic [7:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, {24'h0, x});
  endtask : rd

  task pins(input logic [15:0] oe, input logic [15:0] out);
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    chk(pin_oe, oe);
    chk(pin_out & pin_oe, out);
  endtask : pins

  // ==========================================================================
  // scenarios
  task t_reset;
    rd(OFF_PORT_C_DIRECTION, 8'h00);
    rd(OFF_PORT_E_DIRECTION, 8'h00);
    rd(OFF_LCD_ENABLE_REG_ONE, 8'h01);
    rd(OFF_STANDBY_CONTROL_REG, 8'h00);
    pins(16'h0000, 16'h0000);
  endtask : t_reset

  task t_gpio(input logic p);
    logic [7:0] dat, dir, read_modify_write;
    dat = p ? OFF_PORT_E_DATA_LATCH : OFF_PORT_C_DATA_LATCH;
    dir = p ? OFF_PORT_E_DIRECTION : OFF_PORT_C_DIRECTION;
    read_modify_write = p ? OFF_PORT_E_RMW_VIEW : OFF_PORT_C_RMW_VIEW;
    ext_val <= 16'h3c3c;
    ext_en <= 16'hffff;
    wr(dir, 8'h0f);
    wr(dat, 8'h5a);
    pins(p ? 16'h0f00 : 16'h000f, p ? 16'h0a00 : 16'h000a);
    rd(dat, 8'h3a);
    rd(read_modify_write, 8'h5a);
    wr(dir, 8'h00);
    wr(dat, 8'hff);
    pins(16'h0000, 16'h0000);
    rd(read_modify_write, 8'hff);
    rd(dat, 8'h3c);
  endtask : t_gpio

  task t_lcd;
    ext_en <= 16'h0000;
    lcd_seg_value <= '{e: 8'h06, c: 8'h96};
    wr(OFF_LCD_ENABLE_REG_THREE, 8'h3f);
    wr(OFF_LCD_ENABLE_REG_FOUR, 8'h03);
    wr(OFF_LCD_ENABLE_REG_FIVE, 8'h02);
    wr(OFF_LCD_ENABLE_REG_SIX, 8'h01);
    pins(16'h06ff, 16'h0696);
    wr(OFF_LCD_ENABLE_REG_THREE, 8'h00);
    wr(OFF_LCD_ENABLE_REG_FOUR, 8'h00);
    wr(OFF_LCD_ENABLE_REG_FIVE, 8'h00);
    wr(OFF_LCD_ENABLE_REG_SIX, 8'h00);
    ext_val <= 16'h00c3;
    ext_en <= 16'hffff;
    wr(OFF_LCD_ENABLE_REG_ONE, 8'h00);
    rd(OFF_PORT_C_DATA_LATCH, 8'h00);
    wr(OFF_LCD_ENABLE_REG_ONE, 8'h01);
    rd(OFF_PORT_C_DATA_LATCH, 8'hc3);
    pins(16'h0000, 16'h0000);
  endtask : t_lcd

  task t_timer;
    ext_val <= 16'h8000;
    ta <= 1'b1;
    ta_en <= 1'b1;
    tb <= 1'b0;
    tb_en <= 1'b1;
    pins(16'h6000, 16'h4000);
    chk(timer1_ext_clock, 1'b1);
    wr(OFF_PORT_E_DATA_LATCH, 8'h20);
    wr(OFF_PORT_E_DIRECTION, 8'h60);
    pins(16'h6000, 16'h4000);
    rd(OFF_PORT_E_DATA_LATCH, 8'hc0);
    rd(OFF_PORT_E_RMW_VIEW, 8'h20);
    ta_en <= 1'b0;
    tb_en <= 1'b0;
    pins(16'h6000, 16'h2000);
    wr(OFF_PORT_E_DIRECTION, 8'h00);
  endtask : t_timer

  task t_standby;
    ext_val <= 16'h80ff;
    wr(OFF_PORT_C_DIRECTION, 8'h0f);
    wr(OFF_PORT_C_DATA_LATCH, 8'h0f);
    wr(OFF_STANDBY_CONTROL_REG, 8'h01);
    standby_active <= 1'b1;
    pins(16'h0000, 16'h0000);
    chk(timer1_ext_clock, 1'b0);
    wr(OFF_PORT_C_DIRECTION, 8'h00);
    rd(OFF_PORT_C_DATA_LATCH, 8'h00);
    wr(OFF_PORT_C_DIRECTION, 8'h0f);
    wr(OFF_STANDBY_CONTROL_REG, 8'h00);
    pins(16'h000f, 16'h000f);
    rd(OFF_PORT_C_DATA_LATCH, 8'hff);
    chk(timer1_ext_clock, 1'b1);
    standby_active <= 1'b0;
  endtask : t_standby

  task t_unmapped;
    logic [31:0] r;
    logic e;
    apb(1'b1, 8'h30, 32'h0000_00ff, r, e);
    chk(e, 1'b1);
    apb(1'b0, 8'h30, 32'h0, r, e);
    chk(e, 1'b1);
    chk(r, 32'h0);
    rd(OFF_PORT_C_DATA_LATCH, 8'hff);
  endtask : t_unmapped

  initial begin
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset();
    t_gpio(1'b0);
    t_gpio(1'b1);
    t_lcd();
    t_timer();
    t_standby();
    t_unmapped();
    end_of_test();
  end
endmodule : test_lcd_shared_io_ports
